// >>> design/dswf_top.sv
// Sample word formatter: APB registers for conversion mode and digital bit enable, plus four channel lanes.
// Assumes sample words come from the replay memory on mclk; the option strap is an asynchronous pin.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "dswf_map.svh"

// Functional notes
// R1 - Analog code is word bits 13 to 0
// R2 - Supplier sign-extends bit 13 when digital off; the bench's first, unfitted stream runs with sext low
// R3 - Enabled digital bits come from bits 15,14
// R4 - Passthrough mode leaves words unchanged
// R5 - Twelve-bit mode shifts samples up two
// R6 - Sixteen-bit mode arithmetic shifts down two
// R7 - Select register writes mode, reads mode
// R8 - Capability register reads supported mode bitmask
// R9 - Enable register turns all digital bits on/off
// R10 - Digital bits only when option fitted
// R11 - Digital bits synchronous with analog samples
// R12 - Fixed constant digital latency offset
// R13 - Convert before split; mode resets passthrough
module dswf_top (
  input wire logic mclk, // Sample clock, 40 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [`DSWF_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped accesses or read-only writes
  input wire logic option_fitted, // Strap: digital output option present
  input wire logic in_valid, // Words of all channels present
  input wire logic [`DSWF_NUM_CH*`DSWF_WORD_W-1:0] in_words, // Channel words, channel 0 lowest
  output logic out_valid, // Analog codes valid
  output logic [`DSWF_NUM_CH*`DSWF_CODE_W-1:0] dac_codes, // Analog codes, channel 0 lowest
  output logic [`DSWF_NUM_CH*`DSWF_DIG_W-1:0] dig_outputs // Digital bits, channel 0 lowest
);

  dswf_pkg::dswf_regs_t st_reg;
  dswf_pkg::dswf_regs_t st_next;
  logic setup_ph;
  logic access_ph;
  logic hit_en;
  logic hit_sel;
  logic hit_caps;
  logic hit_stat;
  logic mapped;
  logic wr_ok;
  logic mode_legal;
  logic [`DSWF_NUM_CH-1:0] lane_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign hit_en = (paddr == `DSWF_ADDR_W'(`DSWF_ADDR_DIG_OUT_EN));
  assign hit_sel = (paddr == `DSWF_ADDR_W'(`DSWF_ADDR_CONV_SEL));
  assign hit_caps = (paddr == `DSWF_ADDR_W'(`DSWF_ADDR_CONV_CAPS));
  assign hit_stat = (paddr == `DSWF_ADDR_W'(`DSWF_ADDR_OPT_STATUS));
  assign mapped = hit_en || hit_sel || hit_caps || hit_stat;
  // Read-only registers refuse writes
  assign wr_ok = pwrite ? (hit_en || hit_sel) : mapped;
  assign mode_legal = (pwdata[31:2] == 30'h0000_0000) && (pwdata[1:0] != 2'h3);

  // Zero-wait slave: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access_ph && !wr_ok;
  assign prdata = st_reg.rdata;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    // Strap crosses from an asynchronous pin
    st_next.fit_meta = option_fitted;
    st_next.fit_sync = st_reg.fit_meta;
    // Without the option the enable is forced off and stays off
    if (!st_reg.fit_sync) begin
      st_next.dig_en = 1'b0; // R10
    end
    if (access_ph && pwrite) begin
      if (hit_en) begin
        st_next.dig_en = pwdata[0] && st_reg.fit_sync; // R9 R10
      end
      // Unsupported codes are dropped so the read-back always names a mode in force
      if (hit_sel && mode_legal) begin
        st_next.mode = dswf_pkg::dswf_mode_t'(pwdata[1:0]); // R7
      end
    end
    if (setup_ph && !pwrite) begin
      st_next.rdata = 32'h0000_0000;
      if (hit_en) begin
        st_next.rdata[0] = st_reg.dig_en; // R9
      end
      if (hit_sel) begin
        st_next.rdata[1:0] = st_reg.mode; // R7
      end
      if (hit_caps) begin
        st_next.rdata = `DSWF_CONV_CAPS_VAL; // R8
      end
      if (hit_stat) begin
        st_next.rdata[0] = st_reg.fit_sync;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg.fit_meta <= 1'b0;
      st_reg.fit_sync <= 1'b0;
      st_reg.mode <= dswf_pkg::dswf_mode_t'(`DSWF_MODE_RST); // R13
      st_reg.dig_en <= `DSWF_DIG_EN_RST;
      st_reg.rdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One lane per channel, all sharing mode and enable so channels stay in step
  genvar ch;
  generate
    for (ch = 0; ch < `DSWF_NUM_CH; ch = ch + 1) begin : g_lane
      dswf_lane u_lane (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(in_valid),
        .in_word(in_words[ch*`DSWF_WORD_W +: `DSWF_WORD_W]),
        .mode(st_reg.mode),
        .dig_en(st_reg.dig_en),
        .out_valid(lane_valid[ch]),
        .dac_channel_sample(dac_codes[ch*`DSWF_CODE_W +: `DSWF_CODE_W]),
        .dig_bits(dig_outputs[ch*`DSWF_DIG_W +: `DSWF_DIG_W])
      ); // R11 R12
    end
  endgenerate

  assign out_valid = lane_valid[0];

  ////////////////////////////////////////////////////////////////////////////
  mode_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    (access_ph && pwrite && hit_sel && mode_legal) |=> st_reg.mode == $past(pwdata[1:0]))
    else $error("legal mode write not taken");

  mode_hold_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    (access_ph && pwrite && hit_sel && !mode_legal) |=> $stable(st_reg.mode))
    else $error("illegal mode code changed the mode");

  caps_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    (access_ph && !pwrite && hit_caps) |-> prdata == 32'h0000_0003)
    else $error("capability read returned wrong mask");

  mode_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    (access_ph && !pwrite && hit_sel) |-> prdata == {30'h0000_0000, $past(st_reg.mode)})
    else $error("mode read-back differs from mode in effect");

  enable_write_a: assert property (@(posedge mclk) disable iff (sys_rst) // R9
    (access_ph && pwrite && hit_en && st_reg.fit_sync) |=> st_reg.dig_en == $past(pwdata[0]))
    else $error("enable write not taken on fitted board");

  unfitted_off_a: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    (!st_reg.fit_sync) |=> !st_reg.dig_en)
    else $error("digital enable set without the option");

  mode_reset_a: assert property (@(posedge mclk) // R13
    $fell(sys_rst) |-> st_reg.mode == dswf_pkg::conv_passthrough)
    else $error("mode not passthrough after reset");

  lanes_step_a: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    in_valid |=> (lane_valid == 4'hF))
    else $error("channel lanes out of step");

endmodule

// >>> design/dswf_map.svh
// Register map, field codes, reset values and timing counts of the sample word formatter.
// Included by the package and by both design modules; definitions only.
`ifndef DSWF_MAP_SVH
`define DSWF_MAP_SVH

// Register indices as printed; each register takes one 32-bit word, byte address is four times the index
`define DSWF_IDX_DIG_OUT_EN 20'h1ADB0
`define DSWF_IDX_CONV_SEL 20'h312B8
`define DSWF_IDX_CONV_CAPS 20'h312B9
`define DSWF_IDX_OPT_STATUS 20'h312BF
`define DSWF_ADDR_DIG_OUT_EN (`DSWF_IDX_DIG_OUT_EN << 2)
`define DSWF_ADDR_CONV_SEL (`DSWF_IDX_CONV_SEL << 2)
`define DSWF_ADDR_CONV_CAPS (`DSWF_IDX_CONV_CAPS << 2)
`define DSWF_ADDR_OPT_STATUS (`DSWF_IDX_OPT_STATUS << 2)
`define DSWF_ADDR_W 20

// Conversion mode codes
`define DSWF_CODE_PASSTHROUGH 2'h0
`define DSWF_CODE_WIDEN 2'h1
`define DSWF_CODE_NARROW 2'h2

// Capability bitmask: one bit per supported non-trivial mode code
`define DSWF_CONV_CAPS_VAL 32'h0000_0003

// Reset values
`define DSWF_MODE_RST 2'h0
`define DSWF_DIG_EN_RST 1'b0

// Sample word layout
`define DSWF_WORD_W 16
`define DSWF_CODE_W 14
`define DSWF_DIG_W 2
`define DSWF_NUM_CH 4

// Depth of the digital bit delay line behind the input word, in sample clocks.
// The bits trail the analog code by one clock less, a fixed lag that never varies.
`define DSWF_DIG_OFFSET 2

`endif

// >>> design/dswf_pkg.sv
// Types shared by the sample word formatter modules.
// Relies on dswf_map.svh for all numeric codes.
`include "dswf_map.svh"

package dswf_pkg;

  typedef enum logic [1:0] {
    conv_passthrough = `DSWF_CODE_PASSTHROUGH,
    conv_widen_from_twelve = `DSWF_CODE_WIDEN,
    conv_narrow_from_sixteen = `DSWF_CODE_NARROW
  } dswf_mode_t;

  typedef struct packed {
    logic valid;
    logic [`DSWF_CODE_W-1:0] code;
    logic [`DSWF_DIG_OFFSET-1:0][`DSWF_DIG_W-1:0] dig_pipe;
  } dswf_lane_state_t;

  typedef struct packed {
    logic fit_meta;
    logic fit_sync;
    dswf_mode_t mode;
    logic dig_en;
    logic [31:0] rdata;
  } dswf_regs_t;

endpackage

// >>> design/dswf_lane.sv
// One channel lane: converts a sample word and splits it into analog code and digital bits.
// Assumes words arrive on the sample clock from logic in the same domain.
`timescale 1ns/1ps
`include "dswf_map.svh"

module dswf_lane (
  input wire logic mclk, // Sample clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic in_valid, // Word present this cycle
  input wire logic [`DSWF_WORD_W-1:0] in_word, // Raw sample word
  input wire dswf_pkg::dswf_mode_t mode, // Conversion mode in effect
  input wire logic dig_en, // Digital bits enabled and fitted
  output logic out_valid, // Analog code valid
  output logic [`DSWF_CODE_W-1:0] dac_channel_sample, // Analog code to the converter
  output logic [`DSWF_DIG_W-1:0] dig_bits // Digital output bits
);

  localparam int DLY = `DSWF_DIG_OFFSET;

  dswf_pkg::dswf_lane_state_t st_reg;
  dswf_pkg::dswf_lane_state_t st_next;
  logic [`DSWF_WORD_W-1:0] conv_word;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    // Conversion acts on the whole word before it is split
    unique case (mode)
      dswf_pkg::conv_widen_from_twelve: conv_word = in_word << 2; // R5 R13
      dswf_pkg::conv_narrow_from_sixteen: conv_word = `DSWF_WORD_W'($signed(in_word) >>> 2); // R6 R13
      default: conv_word = in_word; // R4
    endcase
    st_next.valid = in_valid;
    if (in_valid) begin
      st_next.code = conv_word[`DSWF_CODE_W-1:0]; // R1
    end
    // Delay line runs every clock so the digital lag never varies
    st_next.dig_pipe = {st_reg.dig_pipe[DLY-2:0],
      (in_valid && dig_en) ? conv_word[`DSWF_WORD_W-1:`DSWF_CODE_W] : `DSWF_DIG_W'(0)}; // R3 R10 R12
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_valid = st_reg.valid; // R11
  assign dac_channel_sample = st_reg.code;
  assign dig_bits = st_reg.dig_pipe[DLY-1];

  ////////////////////////////////////////////////////////////////////////////
  pass_conv_a: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    (in_valid && mode == dswf_pkg::conv_passthrough) |=> dac_channel_sample == $past(in_word[13:0]))
    else $error("passthrough code differs from input word");

  widen_conv_a: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    (in_valid && mode == dswf_pkg::conv_widen_from_twelve) |=> dac_channel_sample == {$past(in_word[11:0]), 2'h0})
    else $error("widened code is not the input shifted up by two");

  narrow_conv_a: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    (in_valid && mode == dswf_pkg::conv_narrow_from_sixteen) |=> dac_channel_sample == $past(in_word[15:2]))
    else $error("narrowed code is not the input shifted down by two");

  dig_split_a: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    (in_valid && dig_en && mode == dswf_pkg::conv_passthrough) |-> ##DLY dig_bits == $past(in_word[15:14], DLY))
    else $error("digital bits do not follow the upper word bits");

  dig_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    (!dig_en) |-> ##DLY dig_bits == 2'h0)
    else $error("digital bits driven while disabled");

  valid_lat_a: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    in_valid |=> out_valid)
    else $error("analog code not valid one clock after its word");

endmodule

// >>> verif/dswf_replay.sv
// Replay memory model: streams random sample words to the formatter while go is high.
// Assumes go and sext change right after a rising edge of mclk.
`timescale 1ns/1ps
module dswf_replay (
  input wire logic mclk, // Sample clock
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic go, // Stream words while high
  input wire logic sext, // Fill upper bits with the sign copy
  output logic in_valid, // Word set present
  output logic [63:0] in_words // Four channel words, channel 0 lowest
);
  integer seed = 37;
  ////////////////////////////////////////////////////////////////////////////////
  // Random gaps exercise the formatter with both steady and broken streams
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      in_valid <= 1'h0;
      in_words <= 64'h0;
    end else if (go && ($random(seed) % 4 != 0)) begin
      in_valid <= 1'h1;
      for (int i = 0; i < 4; i++) begin
        logic [15:0] w;
        w = 16'($random(seed));
        if (sext) w[15:14] = {2{w[13]}};
        in_words[16*i+:16] <= w;
      end
    end else begin
      in_valid <= 1'h0;
      // Each gap word inverts the word before it, so a first gap never repeats the last set
      in_words <= ~in_words;
    end
  end
endmodule

// >>> verif/tb.sv
// Self-checking bench of the sample word formatter: APB register access and the word stream.
// Assumes the replay model feeds the stream and expectations follow the tracked mode and enable.
`timescale 1ns/1ps
`include "dswf_map.svh"
module tb;
  logic mclk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, option_fitted = 1'h0;
  logic [19:0] paddr = 20'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, in_valid, out_valid, go = 1'h0, sext = 1'h0, er, cur_en = 1'h0, vp = 1'h0;
  logic [63:0] in_words;
  logic [55:0] dac_codes;
  logic [7:0] dig_outputs;
  logic [1:0] cur_mode = 2'h0;
  logic [55:0] cq[$];
  logic [7:0] dq[$];
  int err_count = 0, total_checks = 0;
  always #12.5 mclk = ~mclk;
  dswf_top DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .option_fitted(option_fitted),
    .in_valid(in_valid), .in_words(in_words), .out_valid(out_valid), .dac_codes(dac_codes),
    .dig_outputs(dig_outputs));
  dswf_replay SRC (.mclk(mclk), .sys_rst(sys_rst), .go(go), .sext(sext), .in_valid(in_valid), .in_words(in_words));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    chk("pready", pready, 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdchk(input logic [19:0] a, input logic [31:0] exp, input logic xe);
    apb(1'h0, a, 32'h0);
    chk("read data", rd, exp);
    chk("slave error", er, xe);
  endtask
  task automatic stream(input int n);
    @(posedge mclk);
    go <= 1'h1;
    repeat (n) @(posedge mclk);
    go <= 1'h0;
    repeat (6) @(posedge mclk);
    // Every word sent must have come back out
    chk("pending codes", cq.size(), 64'h0);
    chk("pending digital", dq.size(), 64'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Expected code and digital bits of one word: convert whole word, then split
  function automatic logic [15:0] fmt(input logic [15:0] w);
    logic [15:0] c;
    if (cur_mode == 2'h1) c = w << 2;
    else if (cur_mode == 2'h2) c = $signed(w) >>> 2;
    else c = w;
    return {cur_en ? c[15:14] : 2'h0, c[13:0]};
  endfunction
  always @(posedge mclk) begin
    logic [55:0] ce;
    logic [7:0] de;
    vp <= out_valid === 1'h1;
    if (in_valid === 1'h1) begin
      for (int i = 0; i < 4; i++) {de[2*i+:2], ce[14*i+:14]} = fmt(in_words[16*i+:16]);
      cq.push_back(ce);
      dq.push_back(de);
    end
    // Outputs are unknown until the first reset edge has been seen
    if (sys_rst !== 1'h1) begin
      if (out_valid === 1'h1) chk("codes", dac_codes, cq.pop_front());
      // Digital bits of a word appear one clock after its analog code
      if (vp) chk("digital", dig_outputs, dq.pop_front());
      else chk("idle digital", dig_outputs, 8'h0);
    end
  end
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'h0;
    rdchk(`DSWF_ADDR_CONV_CAPS, 32'h3, 1'h0);
    rdchk(`DSWF_ADDR_CONV_SEL, 32'h0, 1'h0);
    rdchk(20'h00010, 32'h0, 1'h1);
    apb(1'h1, `DSWF_ADDR_CONV_CAPS, 32'h0);
    chk("read-only write", er, 1'h1);
    rdchk(`DSWF_ADDR_CONV_CAPS, 32'h3, 1'h0);
    apb(1'h1, `DSWF_ADDR_DIG_OUT_EN, 32'h1);
    rdchk(`DSWF_ADDR_DIG_OUT_EN, 32'h0, 1'h0);
    rdchk(`DSWF_ADDR_OPT_STATUS, 32'h0, 1'h0);
    stream(10);
    option_fitted <= 1'h1;
    repeat (4) @(posedge mclk);
    rdchk(`DSWF_ADDR_OPT_STATUS, 32'h1, 1'h0);
    for (int e = 0; e < 2; e++) begin
      for (int m = 0; m < 3; m++) begin
        apb(1'h1, `DSWF_ADDR_DIG_OUT_EN, 32'(e));
        apb(1'h1, `DSWF_ADDR_CONV_SEL, 32'(m));
        // An illegal code must leave the mode alone
        apb(1'h1, `DSWF_ADDR_CONV_SEL, 32'h3);
        rdchk(`DSWF_ADDR_CONV_SEL, 32'(m), 1'h0);
        rdchk(`DSWF_ADDR_DIG_OUT_EN, 32'(e), 1'h0);
        cur_mode = 2'(m);
        cur_en = e[0];
        sext <= !e[0];
        stream(16);
      end
    end
    sys_rst <= 1'h1;
    @(posedge mclk);
    sys_rst <= 1'h0;
    rdchk(`DSWF_ADDR_CONV_SEL, 32'h0, 1'h0);
    end_of_test;
  end
endmodule
